/* File: design/drs_pkg.sv */
// Shared constants and types for the strobe-port dynamic RAM controller.
package drs_pkg;

    localparam int ADDR_W = 12;
    localparam int ROW_W  = 6;
    localparam int COL_W  = 6;
    localparam int ROWS   = 64;

    // Address field positions: row in the low bits, column above it.
    localparam int ROW_LSB = 0;
    localparam int COL_LSB = 6;

    localparam int CLK_PERIOD_NS = 10;

    // Times as printed, in nanoseconds.
    localparam int CYCLE_INTERVAL_NS      = 220;
    localparam int STROBE_HIGH_MIN_NS     = 120;
    localparam int STROBE_HIGH_MAX_NS     = 3000;
    localparam int RMW_CYCLE_INTERVAL_NS  = 300;
    localparam int RMW_HIGH_MIN_NS        = 200;
    localparam int STROBE_LOW_INTERVAL_NS = 100;
    localparam int ACCESS_NS              = 100;
    localparam int WRITE_WIDTH_NS         = 80;
    localparam int REFRESH_NS             = 2000000;

    function automatic int ns_ceil(input int ns);
        return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    endfunction

    function automatic int max2(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    // Derived cycle counts at the 100 MHz clock.
    localparam int ACC_CYC       = ns_ceil(ACCESS_NS);
    localparam int WR_CYC        = ns_ceil(WRITE_WIDTH_NS);
    localparam int LOW_MIN_CYC   = ns_ceil(STROBE_LOW_INTERVAL_NS);
    localparam int HIGH_MAX_CYC  = STROBE_HIGH_MAX_NS / CLK_PERIOD_NS;
    localparam int RD_HIGH_CYC   = max2(ns_ceil(STROBE_HIGH_MIN_NS), ACC_CYC + 2);
    localparam int RD_LOW_CYC    = max2(ns_ceil(CYCLE_INTERVAL_NS) - RD_HIGH_CYC,
                                        LOW_MIN_CYC);
    localparam int RMW_HIGH_CYC  = max2(ns_ceil(RMW_HIGH_MIN_NS), ACC_CYC + 1 + WR_CYC);
    localparam int RMW_LOW_CYC   = max2(ns_ceil(RMW_CYCLE_INTERVAL_NS) - RMW_HIGH_CYC,
                                        LOW_MIN_CYC);
    localparam int REFRESH_CYC   = REFRESH_NS / CLK_PERIOD_NS;

    localparam int PH_W  = 9;
    localparam int REF_W = 18;

    typedef enum logic [2:0] {
        DRS_INIT  = 3'b000,
        DRS_PRE   = 3'b001,
        DRS_IDLE  = 3'b010,
        DRS_SETUP = 3'b011,
        DRS_ACT   = 3'b100
    } drs_state_t;

endpackage

/* File: design/drs_phase_counter.sv */
// Elapsed-cycle counter that times each strobe phase.
`timescale 1ns/100ps
module drs_phase_counter #(
    parameter int WIDTH = 9
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             clear,
    output logic [WIDTH-1:0]      count
);
    logic [WIDTH-1:0] count_d;

    // Saturates so a long idle spell never wraps back to a small value.
    always_comb begin
        if (clear) begin
            count_d = '0;
        end else if (count != {WIDTH{1'b1}}) begin
            count_d = count + {{(WIDTH-1){1'b0}}, 1'b1};
        end else begin
            count_d = count;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= '0;
        end else begin
            count <= count_d;
        end
    end
endmodule

/* File: design/drs_host.sv */
// Controller that drives a 4096 x 1 strobe-port dynamic RAM and keeps it refreshed.
`timescale 1ns/100ps
module drs_host
    import drs_pkg::*;
#(
    parameter int REFRESH_PERIOD_CYC = drs_pkg::REFRESH_CYC
) (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic                        req_valid,
    output logic                             req_ready,
    input  wire logic                        req_write,
    input  wire logic                        req_rmw,
    input  wire logic [drs_pkg::ADDR_W-1:0]  req_addr,
    input  wire logic                        req_wdata,
    output logic                             resp_valid,
    output logic                             resp_rdata,
    output logic                             strobe,
    output logic                             select_n,
    output logic                             write_n,
    output logic [drs_pkg::ADDR_W-1:0]       addr,
    output logic                             data_in,
    input  wire logic                        sense_true,
    input  wire logic                        sense_comp
);
    import drs_pkg::*;

    localparam int ROW_INTERVAL_CYC = REFRESH_PERIOD_CYC / ROWS;

    drs_state_t             state_q, state_d;
    logic                   strobe_q, strobe_d;
    logic                   select_n_q, select_n_d;
    logic                   write_n_q, write_n_d;
    logic [ADDR_W-1:0]      addr_q, addr_d;
    logic                   wdata_q, wdata_d;
    logic                   rmw_q, rmw_d;
    logic                   rdata_q, rdata_d;
    logic                   resp_q, resp_d;
    logic                   ref_pend_q, ref_pend_d;
    logic [ROW_W-1:0]       ref_row_q, ref_row_d;
    logic [REF_W-1:0]       ref_cnt_q, ref_cnt_d;
    logic                   ref_tick;
    logic                   ref_issue;
    logic                   ph_clear;
    logic [PH_W-1:0]        ph_cnt;

    function automatic logic ph_at(input logic [PH_W-1:0] cnt, input int n);
        return cnt == PH_W'(n);
    endfunction

    // Places a row and a column into the pin address; refresh cycles use column 0.
    function automatic logic [ADDR_W-1:0] ram_addr(input logic [ROW_W-1:0] row,
                                                   input logic [COL_W-1:0] col);
        logic [ADDR_W-1:0] a;
        a = '0;
        a[ROW_LSB +: ROW_W] = row;
        a[COL_LSB +: COL_W] = col;
        return a;
    endfunction

    // Last phase count of a strobe phase, high or low, for the cycle kind in flight.
    function automatic int phase_last(input logic high, input logic rmw);
        if (high) begin
            return (rmw ? RMW_HIGH_CYC : RD_HIGH_CYC) - 1;
        end
        return (rmw ? RMW_LOW_CYC : RD_LOW_CYC) - 1;
    endfunction

    drs_phase_counter #(
        .WIDTH (PH_W)
    ) u_phase (
        .clk   (clk),
        .rst   (rst),
        .clear (ph_clear),
        .count (ph_cnt)
    );

    assign req_ready  = (state_q == DRS_IDLE) && !ref_pend_q;
    assign resp_valid = resp_q;
    assign resp_rdata = rdata_q;
    assign strobe     = strobe_q;
    assign select_n   = select_n_q;
    assign write_n    = write_n_q;
    assign addr       = addr_q;
    assign data_in    = wdata_q;

    // One row is due every interval; a due row is never dropped by a clear.
    assign ref_tick  = (ref_cnt_q == REF_W'(ROW_INTERVAL_CYC - 1));
    assign ref_issue = (state_q == DRS_IDLE) && ref_pend_q;

    always_comb begin
        ref_cnt_d  = ref_tick ? '0 : ref_cnt_q + REF_W'(1);
        ref_pend_d = (ref_pend_q && !ref_issue) || ref_tick;
        ref_row_d  = ref_issue ? ref_row_q + ROW_W'(1) : ref_row_q;
    end

    always_comb begin
        state_d    = state_q;
        strobe_d   = strobe_q;
        select_n_d = select_n_q;
        write_n_d  = write_n_q;
        addr_d     = addr_q;
        wdata_d    = wdata_q;
        rmw_d      = rmw_q;
        rdata_d    = rdata_q;
        resp_d     = 1'b0;
        ph_clear   = 1'b0;
        case (state_q)
            DRS_INIT: begin
                // Dummy high phase so the first real cycle follows a falling strobe.
                strobe_d = 1'b1;
                // Counting starts one edge before the rise, so the end count is one higher.
                if (ph_at(ph_cnt, RD_HIGH_CYC) && strobe_q) begin
                    strobe_d = 1'b0;
                    ph_clear = 1'b1;
                    state_d  = DRS_PRE;
                end
            end
            DRS_PRE: begin
                if (ph_at(ph_cnt, phase_last(1'b0, rmw_q))) begin
                    state_d = DRS_IDLE;
                end
            end
            DRS_IDLE: begin
                if (ref_pend_q) begin
                    // Read-type refresh with select high: the write path stays idle.
                    addr_d     = ram_addr(ref_row_q, COL_W'(0));
                    select_n_d = 1'b1;
                    write_n_d  = 1'b1;
                    rmw_d      = 1'b0;
                    state_d    = DRS_SETUP;
                end else if (req_valid) begin
                    addr_d     = req_addr;
                    select_n_d = 1'b0;
                    write_n_d  = !(req_write && !req_rmw);
                    wdata_d    = req_wdata;
                    rmw_d      = req_rmw;
                    state_d    = DRS_SETUP;
                end
            end
            DRS_SETUP: begin
                // Address and controls have settled for a cycle before the rise.
                strobe_d = 1'b1;
                ph_clear = 1'b1;
                state_d  = DRS_ACT;
            end
            DRS_ACT: begin
                if (ph_at(ph_cnt, ACC_CYC) && write_n_q) begin
                    rdata_d = sense_true && !sense_comp;
                end
                if (rmw_q && ph_at(ph_cnt, ACC_CYC)) begin
                    write_n_d = 1'b0;
                end
                if (ph_at(ph_cnt, phase_last(1'b1, rmw_q))) begin
                    strobe_d   = 1'b0;
                    select_n_d = 1'b1;
                    write_n_d  = 1'b1;
                    resp_d     = !(select_n_q);
                    ph_clear   = 1'b1;
                    state_d    = DRS_PRE;
                end
            end
            default: begin
                strobe_d   = 1'b0;
                select_n_d = 1'b1;
                write_n_d  = 1'b1;
                ph_clear   = 1'b1;
                state_d    = DRS_PRE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q    <= DRS_INIT;
            strobe_q   <= 1'b0;
            select_n_q <= 1'b1;
            write_n_q  <= 1'b1;
            addr_q     <= '0;
            wdata_q    <= 1'b0;
            rmw_q      <= 1'b0;
            rdata_q    <= 1'b0;
            resp_q     <= 1'b0;
            ref_pend_q <= 1'b0;
            ref_row_q  <= '0;
            ref_cnt_q  <= '0;
        end else begin
            state_q    <= state_d;
            strobe_q   <= strobe_d;
            select_n_q <= select_n_d;
            write_n_q  <= write_n_d;
            addr_q     <= addr_d;
            wdata_q    <= wdata_d;
            rmw_q      <= rmw_d;
            rdata_q    <= rdata_d;
            resp_q     <= resp_d;
            ref_pend_q <= ref_pend_d;
            ref_row_q  <= ref_row_d;
            ref_cnt_q  <= ref_cnt_d;
        end
    end
endmodule

/* File: testbench/drs_host_checker.sv */
// Pin-level assertions for the strobe-port RAM controller.
`timescale 1ns/100ps
module drs_host_checker #(
    parameter int REFRESH_PERIOD_CYC = 6400
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire logic        req_write,
    input wire logic        req_rmw,
    input wire logic [11:0] req_addr,
    input wire logic        req_wdata,
    input wire logic        resp_valid,
    input wire logic        resp_rdata,
    input wire logic        strobe,
    input wire logic        select_n,
    input wire logic        write_n,
    input wire logic [11:0] addr,
    input wire logic        data_in,
    input wire logic        sense_true,
    input wire logic        sense_comp
);
    localparam int ROW_CYC = REFRESH_PERIOD_CYC / 64;
    int low_run;
    // Counts consecutive low samples of the strobe; row refresh must break every run.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_run <= 0;
        end else begin
            low_run <= strobe ? 0 : low_run + 1;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    property p_low_max; low_run < ROW_CYC; endproperty
    a_low_max: assert property (p_low_max) else $error("strobe low too long");
    property p_take; req_valid && req_ready |=> !select_n && !strobe ##1 strobe; endproperty
    a_take: assert property (p_take) else $error("no cycle after take");
    property p_addr; strobe && $past(strobe) |-> $stable(addr); endproperty
    a_addr: assert property (p_addr) else $error("address moved");
    property p_high; $rose(strobe) |-> ##4 strobe [*8]; endproperty
    a_high: assert property (p_high) else $error("strobe high short");
    property p_low; $fell(strobe) |-> ##2 !strobe [*8]; endproperty
    a_low: assert property (p_low) else $error("strobe low short");
    property p_rmw; $fell(write_n) && strobe |-> $past(strobe, 8) && !select_n; endproperty
    a_rmw: assert property (p_rmw) else $error("write fell early");
    property p_din; strobe && !write_n && $past(strobe) |-> $stable(data_in); endproperty
    a_din: assert property (p_din) else $error("data moved");
    property p_ref; strobe && select_n |-> write_n; endproperty
    a_ref: assert property (p_ref) else $error("write while deselected");
    property p_resp; resp_valid |-> $fell(strobe); endproperty
    a_resp: assert property (p_resp) else $error("answer off strobe end");
endmodule
bind drs_host drs_host_checker #(
    .REFRESH_PERIOD_CYC (REFRESH_PERIOD_CYC)
) u_chk (
    .clk        (clk),
    .rst        (rst),
    .req_valid  (req_valid),
    .req_ready  (req_ready),
    .req_write  (req_write),
    .req_rmw    (req_rmw),
    .req_addr   (req_addr),
    .req_wdata  (req_wdata),
    .resp_valid (resp_valid),
    .resp_rdata (resp_rdata),
    .strobe     (strobe),
    .select_n   (select_n),
    .write_n    (write_n),
    .addr       (addr),
    .data_in    (data_in),
    .sense_true (sense_true),
    .sense_comp (sense_comp)
);

/* File: testbench/drs_ram_model.sv */
// Behavioural 4096 x 1 strobe-port dynamic RAM.
`timescale 1ns/100ps
module drs_ram_model #(
    parameter int DLY = 7,
    parameter int LIM = 6600
) (
    input  wire logic        clk,
    input  wire logic        strobe,
    input  wire logic        select_n,
    input  wire logic        write_n,
    input  wire logic [11:0] addr,
    input  wire logic        data_in,
    output logic             sense_true,
    output logic             sense_comp
);
    logic mem [4096];
    int last [64];
    int cyc = 0;
    int cnt = 0;
    logic st_q = 1'b0;
    logic tog = 1'b0;
    logic [11:0] a_q = 12'h000;
    logic [11:0] wa;
    logic bv;
    initial foreach (mem[i]) mem[i] = 1'b0;
    assign wa = st_q ? a_q : addr;
    assign bv = write_n ? mem[wa] : data_in;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        tog <= ~tog;
        st_q <= strobe;
        cnt <= strobe ? cnt + 1 : 0;
        if (strobe && !st_q) begin
            a_q <= addr;
            last[addr[5:0]] <= cyc;
            if (cyc - last[addr[5:0]] > LIM) begin
                for (int c = 0; c < 64; c++) begin
                    mem[{c[5:0], addr[5:0]}] <= ~mem[{c[5:0], addr[5:0]}];
                end
            end
        end
        if (strobe && !select_n && !write_n) mem[wa] <= data_in;
    end
    // Released lines toggle so a stale level never reads as data.
    always_comb begin
        sense_true = tog;
        sense_comp = tog;
        if (strobe && !select_n && cnt >= DLY) begin
            sense_true = bv;
            sense_comp = ~bv;
        end
    end
endmodule

/* File: testbench/tb_dynamic_ram_4k_x1_strobe_port.sv */
// Self-checking bench for the strobe-port RAM controller.
`timescale 1ns/100ps
module tb_dynamic_ram_4k_x1_strobe_port;
    localparam int RP = 6400;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic req_rmw = 1'b0;
    logic [11:0] req_addr = 12'h000;
    logic req_wdata = 1'b0;
    logic req_ready, resp_valid, resp_rdata, strobe, select_n, write_n, data_in;
    logic sense_true, sense_comp, prev;
    logic [11:0] addr;
    logic [31:0] r;
    logic [11:0] cn [5] = '{12'h000, 12'h03F, 12'hFC0, 12'hFFF, 12'h041};
    int ref_mem [4096];
    int failures = 0;
    int samples_checked = 0;
    int seed = 32'h7362D1A7;
    int n;
    int rises;
    always #5 clk = ~clk;
    drs_host #(
        .REFRESH_PERIOD_CYC (RP)
    ) dut (
        .clk        (clk),
        .rst        (rst),
        .req_valid  (req_valid),
        .req_ready  (req_ready),
        .req_write  (req_write),
        .req_rmw    (req_rmw),
        .req_addr   (req_addr),
        .req_wdata  (req_wdata),
        .resp_valid (resp_valid),
        .resp_rdata (resp_rdata),
        .strobe     (strobe),
        .select_n   (select_n),
        .write_n    (write_n),
        .addr       (addr),
        .data_in    (data_in),
        .sense_true (sense_true),
        .sense_comp (sense_comp)
    );
    drs_ram_model #(
        .LIM (RP + 200)
    ) u_ram (
        .clk        (clk),
        .strobe     (strobe),
        .select_n   (select_n),
        .write_n    (write_n),
        .addr       (addr),
        .data_in    (data_in),
        .sense_true (sense_true),
        .sense_comp (sense_comp)
    );
    task automatic chk(input string nm, input logic seen, input logic exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %b seen %b", nm, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic tick(input int lim);
        @(negedge clk);
        n++;
        if (n > lim) begin
            failures++;
            wrap_up();
        end
    endtask
    task automatic op(input logic w, input logic m, input logic [11:0] a, input logic d);
        logic exp;
        exp = ref_mem[a][0];
        {req_write, req_rmw, req_addr, req_wdata, req_valid} = {w, m, a, d, 1'b1};
        n = 0;
        while (req_ready !== 1'b1) tick(200);
        @(negedge clk);
        req_valid = 1'b0;
        n = 0;
        while (resp_valid !== 1'b1) tick(40);
        if (!w || m) chk("read bit", resp_rdata, exp);
        if (w || m) ref_mem[a] = {31'h0, d};
    endtask
    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        foreach (cn[i]) op(1'b1, 1'b0, cn[i], 1'b1);
        foreach (cn[i]) op(1'b0, 1'b0, cn[i], 1'b0);
        $display("corner write and read done");
        foreach (cn[i]) op(1'b0, 1'b1, cn[i], i[0]);
        foreach (cn[i]) op(1'b0, 1'b0, cn[i], 1'b0);
        $display("read-modify-write done");
        repeat (300) begin
            r = $random(seed);
            op(r[0], r[1], r[13:2], r[14]);
        end
        $display("random traffic done");
        rises = 0;
        prev = strobe;
        repeat (2 * RP) begin
            @(negedge clk);
            rises += int'(strobe && !prev);
            prev = strobe;
        end
        chk("row refresh count", rises >= 128, 1'b1);
        foreach (cn[i]) op(1'b0, 1'b0, cn[i], 1'b0);
        $display("refresh retention done");
        wrap_up();
    end
endmodule
